/* core/twmc_pkg.sv */
// Constants and types for the timer waveform mode control block.
// Assumes a 20 MHz core clock and an APB master with 32-bit data.
package twmc_pkg;
  localparam int ADDR_W = 12;
  localparam int PRESC_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [7:0] CTRL_A_IDX = 8'hB0;
  localparam logic [7:0] CTRL_B_IDX = 8'hB1;
  localparam logic [7:0] COUNT_IDX = 8'hB2;
  localparam logic [7:0] CMP_A_IDX = 8'hB3;
  localparam logic [7:0] CMP_B_IDX = 8'hB4;
  localparam logic [7:0] FLAGS_IDX = 8'hB5;
  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  // Writable bits
  localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
  localparam logic [7:0] CTRL_B_WMASK = 8'h0F;
  // Field positions
  localparam int COM_A_LSB = 6;
  localparam int COM_B_LSB = 4;
  localparam int WGM_LO_LSB = 0;
  localparam int FOC_A_BIT = 7;
  localparam int FOC_B_BIT = 6;
  localparam int WGM_TOP_BIT = 3;
  localparam int CS_LSB = 0;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMPA_BIT = 1;
  localparam int FLAG_CMPB_BIT = 2;
  // Counter landmarks
  localparam logic [7:0] MAX_VAL = 8'hFF;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  // Waveform generation modes
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PHASE_FF = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_FF = 3'h3;
  localparam logic [2:0] WGM_PHASE_A = 3'h5;
  localparam logic [2:0] WGM_FAST_A = 3'h7;
  // Compare output mode codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // Prescaler masks per clock select value
  localparam logic [PRESC_W-1:0] DIV1_MASK = 10'h000;
  localparam logic [PRESC_W-1:0] DIV8_MASK = 10'h007;
  localparam logic [PRESC_W-1:0] DIV32_MASK = 10'h01F;
  localparam logic [PRESC_W-1:0] DIV64_MASK = 10'h03F;
  localparam logic [PRESC_W-1:0] DIV128_MASK = 10'h07F;
  localparam logic [PRESC_W-1:0] DIV256_MASK = 10'h0FF;
  localparam logic [PRESC_W-1:0] DIV1024_MASK = 10'h3FF;
  typedef enum logic [2:0] {KIND_NORMAL, KIND_CTC, KIND_FAST, KIND_PHASE, KIND_RSVD} twmc_kind_t;
  typedef enum logic {DIR_UP, DIR_DOWN} twmc_dir_t;
endpackage

/* core/twmc_top.sv */
// Timer with waveform generation, mode control and force strobes on APB.
// Assumes one 20 MHz clock; pin direction is set outside this block.
// Function
// - Channel A nonzero mode overrides pin
// - Non-PWM channel A: off, toggle, clear, set
// - Fast PWM channel A codes act per table
// - Fast PWM A: compare at TOP acts at BOTTOM
// - Phase PWM A: up/down match actions per code
// - Phase PWM: compare at TOP acts at TOP
// - Channel B nonzero mode overrides pin
// - Non-PWM channel B: off, toggle, clear, set
// - Fast PWM channel B: 01 reserved, 10/11
// - Phase PWM channel B: 01 reserved, 10/11
// - Three-bit mode; modes 4, 6 reserved
// - TOP source and compare update point per mode
// - Overflow flag at MAX, BOTTOM or TOP
// - Force A honoured only in non-PWM modes
// - Force A applies current channel A action
// - Force is a one-shot strobe
// - Force sets no flag, clears no counter
// - Force A bit always reads zero
// - Force B behaves like force A
// - Clock select stops or divides timer clock
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module twmc_top (
  input logic core_clk,
  input logic resetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [twmc_pkg::ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic chanAWaveOut,
  output logic chanBWaveOut,
  output logic chanAPinOverride,
  output logic chanBPinOverride,
  output logic overflowFlag
);
  import twmc_pkg::*;

  logic [7:0] ctrlA_r;
  logic [7:0] ctrlB_r;
  logic [7:0] count_r;
  logic [7:0] cmpBuf_r [2];
  logic [7:0] cmpAct_r [2];
  logic [2:0] flags_r;
  logic [PRESC_W-1:0] presc_r;
  twmc_dir_t dir_r;
  logic [1:0] force_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [7:0] rdMux;
  logic [2:0] wgm;
  twmc_kind_t kind;
  logic [7:0] topVal;
  logic tick;
  logic atTop;
  logic ovfEv;
  logic wr;
  logic [7:0] wbyte;
  logic isMapped;
  logic cmpImmediate;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction

  function automatic twmc_kind_t modeKind(input logic [2:0] m);
    case (m)
      WGM_NORMAL: modeKind = KIND_NORMAL;
      WGM_CTC: modeKind = KIND_CTC;
      WGM_PHASE_FF, WGM_PHASE_A: modeKind = KIND_PHASE;
      WGM_FAST_FF, WGM_FAST_A: modeKind = KIND_FAST;
      default: modeKind = KIND_RSVD;
    endcase
  endfunction

  function automatic logic [PRESC_W-1:0] divMask(input logic [2:0] cs);
    case (cs)
      3'h1: divMask = DIV1_MASK;
      3'h2: divMask = DIV8_MASK;
      3'h3: divMask = DIV32_MASK;
      3'h4: divMask = DIV64_MASK;
      3'h5: divMask = DIV128_MASK;
      3'h6: divMask = DIV256_MASK;
      3'h7: divMask = DIV1024_MASK;
      default: divMask = DIV1_MASK;
    endcase
  endfunction

  function automatic logic applyAct(input logic cur, input logic [1:0] com);
    case (com)
      COM_TOGGLE: applyAct = !cur;
      COM_CLEAR: applyAct = 1'b0;
      COM_SET: applyAct = 1'b1;
      default: applyAct = cur;
    endcase
  endfunction

  // APB: one wait state, write and read complete at the pready edge
  assign wr = psel && penable && pready_r && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign isMapped = hit(paddr, CTRL_A_IDX) || hit(paddr, CTRL_B_IDX) ||
    hit(paddr, COUNT_IDX) || hit(paddr, CMP_A_IDX) || hit(paddr, CMP_B_IDX) ||
    hit(paddr, FLAGS_IDX);

  always_comb begin
    rdMux = 8'h00;
    if (hit(paddr, CTRL_A_IDX)) rdMux = ctrlA_r;
    if (hit(paddr, CTRL_B_IDX)) rdMux = ctrlB_r;
    if (hit(paddr, COUNT_IDX)) rdMux = count_r;
    if (hit(paddr, CMP_A_IDX)) rdMux = cmpBuf_r[0];
    if (hit(paddr, CMP_B_IDX)) rdMux = cmpBuf_r[1];
    if (hit(paddr, FLAGS_IDX)) rdMux = {5'h00, flags_r};
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !isMapped;
      prdata_r <= (psel && penable && !pready_r && !pwrite) ? {24'h000000, rdMux} : 32'h0;
    end
  end

  // Force bits are never stored, so they read back as zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrlA_r <= CTRL_A_RST;
      ctrlB_r <= CTRL_B_RST;
    end else begin
      if (wr && hit(paddr, CTRL_A_IDX)) ctrlA_r <= wbyte & CTRL_A_WMASK;
      if (wr && hit(paddr, CTRL_B_IDX)) ctrlB_r <= wbyte & CTRL_B_WMASK;
    end
  end

  // Mode judged from the value being written, so a write that enters PWM forces nothing
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      force_r <= 2'b00;
    end else begin
      force_r <= 2'b00;
      if (wr && hit(paddr, CTRL_B_IDX) &&
          modeKind({wbyte[WGM_TOP_BIT], ctrlA_r[WGM_LO_LSB +: 2]}) inside {KIND_NORMAL, KIND_CTC})
      begin
        force_r <= {wbyte[FOC_B_BIT], wbyte[FOC_A_BIT]};
      end
    end
  end

  assign wgm = {ctrlB_r[WGM_TOP_BIT], ctrlA_r[WGM_LO_LSB +: 2]};
  assign kind = modeKind(wgm);
  assign topVal = (wgm == WGM_CTC || wgm == WGM_PHASE_A || wgm == WGM_FAST_A) ?
    cmpAct_r[0] : MAX_VAL;
  assign tick = (ctrlB_r[CS_LSB +: 3] != 3'h0) &&
    ((presc_r & divMask(ctrlB_r[CS_LSB +: 3])) == divMask(ctrlB_r[CS_LSB +: 3]));
  assign atTop = tick && (kind != KIND_RSVD) && (count_r == topVal) && (dir_r == DIR_UP);
  assign cmpImmediate = (kind == KIND_NORMAL) || (kind == KIND_CTC) || (kind == KIND_RSVD);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + 10'h001;
    end
  end

  // Counter; a software write wins over counting
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      count_r <= COUNT_RST;
      dir_r <= DIR_UP;
    end else if (wr && hit(paddr, COUNT_IDX)) begin
      count_r <= wbyte;
    end else if (tick) begin
      case (kind)
        KIND_NORMAL: count_r <= count_r + 8'h01;
        KIND_CTC, KIND_FAST: begin
          count_r <= (count_r == topVal) ? BOTTOM_VAL : count_r + 8'h01;
        end
        KIND_PHASE: begin
          if (dir_r == DIR_UP) begin
            if (count_r == topVal) begin
              dir_r <= DIR_DOWN;
              count_r <= (count_r == BOTTOM_VAL) ? count_r : count_r - 8'h01;
            end else begin
              count_r <= count_r + 8'h01;
            end
          end else if (count_r == BOTTOM_VAL) begin
            dir_r <= DIR_UP;
            count_r <= count_r + 8'h01;
          end else begin
            count_r <= count_r - 8'h01;
          end
        end
        default: count_r <= count_r;
      endcase
    end
  end

  // Double-buffered compare values
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int i = 0; i < 2; i++) begin
        cmpBuf_r[i] <= CMP_RST;
        cmpAct_r[i] <= CMP_RST;
      end
    end else begin
      if (wr && hit(paddr, CMP_A_IDX)) cmpBuf_r[0] <= wbyte;
      if (wr && hit(paddr, CMP_B_IDX)) cmpBuf_r[1] <= wbyte;
      for (int i = 0; i < 2; i++) begin
        if (cmpImmediate || atTop) cmpAct_r[i] <= cmpBuf_r[i];
      end
    end
  end

  always_comb begin
    case (wgm)
      WGM_NORMAL, WGM_CTC, WGM_FAST_FF: begin
        ovfEv = tick && (count_r == MAX_VAL) && (dir_r == DIR_UP);
      end
      WGM_PHASE_FF, WGM_PHASE_A: ovfEv = tick && (dir_r == DIR_DOWN) && (count_r == BOTTOM_VAL);
      WGM_FAST_A: ovfEv = atTop;
      default: ovfEv = 1'b0;
    endcase
  end

  // Waveform units; forced matches never reach the flags
  for (genvar ch = 0; ch < 2; ch++) begin : chanG
    logic [1:0] com;
    logic matchEv;
    logic cmpIsTop;
    logic wave_r;
    logic wave_nxt;
    logic over_r;
    assign com = (ch == 0) ? ctrlA_r[COM_A_LSB +: 2] : ctrlA_r[COM_B_LSB +: 2];
    assign matchEv = tick && (kind != KIND_RSVD) && (count_r == cmpAct_r[ch]);
    assign cmpIsTop = (cmpAct_r[ch] == topVal);
    always_comb begin
      wave_nxt = wave_r;
      case (kind)
        KIND_NORMAL, KIND_CTC: begin
          if (matchEv) wave_nxt = applyAct(wave_r, com);
          if (force_r[ch]) wave_nxt = applyAct(wave_r, com);
        end
        KIND_FAST: begin
          if (com == COM_TOGGLE) begin
            if (ch == 0 && wgm[2] && matchEv) wave_nxt = !wave_r;
          end else if (com[1]) begin
            if (matchEv && !cmpIsTop) wave_nxt = com[0];
            if (atTop) wave_nxt = !com[0];
          end
        end
        KIND_PHASE: begin
          if (com == COM_TOGGLE) begin
            if (ch == 0 && wgm[2] && matchEv) wave_nxt = !wave_r;
          end else if (com[1]) begin
            if (matchEv && !cmpIsTop) begin
              wave_nxt = (dir_r == DIR_UP) ? com[0] : !com[0];
            end
            if (atTop && cmpIsTop) wave_nxt = !com[0];
          end
        end
        default: wave_nxt = wave_r;
      endcase
    end
    always_ff @(posedge core_clk) begin
      if (!resetn) begin
        wave_r <= 1'b0;
        over_r <= 1'b0;
      end else begin
        wave_r <= wave_nxt;
        over_r <= (com != COM_OFF);
      end
    end
  end

  // Sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= (flags_r & ~((wr && hit(paddr, FLAGS_IDX)) ? wbyte[2:0] : 3'h0)) |
        {chanG[1].matchEv, chanG[0].matchEv, ovfEv};
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign chanAWaveOut = chanG[0].wave_r;
  assign chanBWaveOut = chanG[1].wave_r;
  assign chanAPinOverride = chanG[0].over_r;
  assign chanBPinOverride = chanG[1].over_r;
  assign overflowFlag = flags_r[FLAG_OVF_BIT];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  logic cntWr;
  assign cntWr = wr && hit(paddr, COUNT_IDX);

  a_override_a: assert property (ctrlA_r[COM_A_LSB +: 2] != COM_OFF
    |=> chanAPinOverride)
    else $error("channel A pin not overridden");
  a_override_b: assert property (ctrlA_r[COM_B_LSB +: 2] == COM_OFF
    |=> !chanBPinOverride)
    else $error("channel B pin overridden while off");
  a_nonpwm_set: assert property (kind == KIND_NORMAL && chanG[0].matchEv &&
    chanG[0].com == COM_SET |=> chanAWaveOut)
    else $error("non-PWM set on match failed");
  a_nonpwm_toggle_b: assert property (kind == KIND_CTC && chanG[1].matchEv &&
    chanG[1].com == COM_TOGGLE && !force_r[1] |=> chanBWaveOut != $past(chanBWaveOut))
    else $error("non-PWM toggle on B failed");
  a_fast_bottom: assert property (kind == KIND_FAST && atTop &&
    chanG[0].com == COM_CLEAR |=> chanAWaveOut)
    else $error("fast PWM A not set at bottom");
  a_fast_invert_b: assert property (kind == KIND_FAST && chanG[1].matchEv &&
    !chanG[1].cmpIsTop && chanG[1].com == COM_SET |=> chanBWaveOut)
    else $error("fast PWM B inverting match failed");
  a_phase_up_clear: assert property (kind == KIND_PHASE && chanG[0].matchEv &&
    dir_r == DIR_UP && !chanG[0].cmpIsTop && chanG[0].com == COM_CLEAR |=> !chanAWaveOut)
    else $error("phase PWM up match did not clear");
  a_phase_down_b: assert property (kind == KIND_PHASE && chanG[1].matchEv &&
    dir_r == DIR_DOWN && !chanG[1].cmpIsTop && chanG[1].com == COM_SET |=> !chanBWaveOut)
    else $error("phase PWM B down match did not clear");
  a_phase_top_set: assert property (kind == KIND_PHASE && atTop && chanG[1].cmpIsTop &&
    chanG[1].com == COM_CLEAR |=> chanBWaveOut)
    else $error("phase PWM top special case failed");
  a_reserved_b: assert property (kind inside {KIND_FAST, KIND_PHASE} &&
    chanG[1].com == COM_TOGGLE |=> $stable(chanBWaveOut))
    else $error("reserved code moved B output");
  a_force_strobe: assert property (force_r[0] |=> !force_r[0])
    else $error("force strobe longer than one cycle");
  a_force_toggle: assert property (force_r[0] && !chanG[0].matchEv &&
    chanG[0].com == COM_TOGGLE |=> chanAWaveOut != $past(chanAWaveOut))
    else $error("forced toggle did not act");
  a_force_pwm: assert property (wr && hit(paddr, CTRL_B_IDX) &&
    modeKind({wbyte[WGM_TOP_BIT], ctrlA_r[1:0]}) inside {KIND_FAST, KIND_PHASE}
    |=> force_r == 2'b00)
    else $error("force honoured in PWM mode");
  a_force_noflag: assert property (force_r[0] && !chanG[0].matchEv
    |=> flags_r[FLAG_CMPA_BIT] == $past(flags_r[FLAG_CMPA_BIT]) ||
    $past(wr && hit(paddr, FLAGS_IDX)))
    else $error("force raised a flag");
  a_force_read: assert property (pready && !pwrite && hit(paddr, CTRL_B_IDX)
    |-> prdata[7:4] == 4'h0)
    else $error("force bits read nonzero");
  a_phase_ovf: assert property (kind == KIND_PHASE && tick && dir_r == DIR_DOWN &&
    count_r == BOTTOM_VAL |=> overflowFlag)
    else $error("phase PWM overflow not flagged");
  a_ctc_clear: assert property (kind == KIND_CTC && tick && count_r == cmpAct_r[0] &&
    !cntWr |=> count_r == BOTTOM_VAL)
    else $error("CLEAR_ON_MATCH_MODE did not clear at compare A");
  a_clock_stop: assert property (ctrlB_r[CS_LSB +: 3] == 3'h0 && !cntWr
    |=> $stable(count_r))
    else $error("stopped counter moved");
  a_reserved_mode: assert property (kind == KIND_RSVD && !cntWr |=> $stable(count_r))
    else $error("counter moved in reserved mode");
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("APB answer late");

  c_fast_pwm: cover property (kind == KIND_FAST && atTop ##1 chanAWaveOut);
  c_phase_turn: cover property (kind == KIND_PHASE && atTop ##[1:300] ovfEv);
  c_force_a: cover property (force_r[0] ##1 chanAWaveOut);
  c_apb_error: cover property (pready && pslverr);
endmodule

/* testbench/tb_twmc_top.sv */
// Self-checking bench for the timer waveform mode control block.
// Assumes the APB slave answers with pready in a bounded number of cycles.
// Pin direction is owned by software outside; only the override is seen
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_twmc_top;
  import twmc_pkg::*;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic chanAWaveOut, chanBWaveOut, chanAPinOverride, chanBPinOverride, overflowFlag;
  int err_total, total_checks, hi, hib;
  int divs [7] = '{1, 8, 32, 64, 128, 256, 1024};
  logic [7:0] rdv;
  logic errv;

  twmc_top i_twmc_top (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .chanAWaveOut(chanAWaveOut),
    .chanBWaveOut(chanBWaveOut), .chanAPinOverride(chanAPinOverride),
    .chanBPinOverride(chanBPinOverride), .overflowFlag(overflowFlag));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task results;
    $display("Checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Request held until pready is seen at a rising edge, then released
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ADDR_W'({idx, 2'b00});
    pwdata <= {24'h000000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("Error pready expected 1 seen %b", pready);
      results();
    end else begin
      rdv = prdata[7:0];
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic hi_count(input int cyc);
    hi = 0;
    hib = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      if (chanAWaveOut === 1'b1) hi++;
      if (chanBWaveOut === 1'b1) hib++;
    end
  endtask

  task t_regs;
    apb(0, CTRL_A_IDX, 8'h00); `CHK("ctrl a reset", CTRL_A_RST, rdv)
    apb(0, CTRL_B_IDX, 8'h00); `CHK("ctrl b reset", CTRL_B_RST, rdv)
    apb(0, 8'hC0, 8'h00); `CHK("unmapped err", 1'b1, errv)
    `CHK("unmapped data", 8'h00, rdv)
    apb(1, CTRL_A_IDX, 8'hFF);
    apb(0, CTRL_A_IDX, 8'h00); `CHK("ctrl a bits", 8'hF3, rdv)
    `CHK("override a", 1'b1, chanAPinOverride)
    `CHK("override b", 1'b1, chanBPinOverride)
    apb(1, CTRL_A_IDX, 8'h00);
    apb(1, CTRL_B_IDX, 8'hC8);
    apb(0, CTRL_B_IDX, 8'h00); `CHK("force bits read", 8'h08, rdv)
    apb(1, CTRL_B_IDX, 8'h00);
    `CHK("override a off", 1'b0, chanAPinOverride)
  endtask

  // Counter stopped, normal mode: only forced matches move the outputs
  task t_force;
    logic [1:0] c;
    for (int i = 0; i < 3; i++) begin
      c = 2'(i + 1);
      apb(1, CTRL_A_IDX, {c, 6'h00});
      // Override follows the mode register one clock later
      repeat (2) @(posedge core_clk);
      `CHK("override a on", 1'b1, chanAPinOverride)
      `CHK("override b idle", 1'b0, chanBPinOverride)
      apb(1, CTRL_B_IDX, 8'h80);
      repeat (6) @(posedge core_clk);
      `CHK("forced a", (i != 1), chanAWaveOut)
    end
    for (int i = 0; i < 3; i++) begin
      c = 2'(i + 1);
      apb(1, CTRL_A_IDX, {COM_SET, c, 4'h0});
      repeat (2) @(posedge core_clk);
      `CHK("override b on", 1'b1, chanBPinOverride)
      apb(1, CTRL_B_IDX, 8'h40);
      repeat (6) @(posedge core_clk);
      `CHK("forced b", (i != 1), chanBWaveOut)
      `CHK("a kept", 1'b1, chanAWaveOut)
    end
    apb(0, FLAGS_IDX, 8'h00); `CHK("no flag", 8'h00, rdv)
    apb(0, COUNT_IDX, 8'h00); `CHK("no clear", 8'h00, rdv)
    // Force written in a PWM mode on purpose, to show it is ignored
    apb(1, CTRL_A_IDX, {COM_CLEAR, 4'h0, 2'b11});
    apb(1, CTRL_B_IDX, 8'h80);
    repeat (6) @(posedge core_clk);
    `CHK("pwm force ignored", 1'b1, chanAWaveOut)
  endtask

  // Channel A non-inverting, channel B inverting on the same compare value
  task t_fast_pwm;
    apb(1, CMP_A_IDX, 8'h40);
    apb(1, CMP_B_IDX, 8'h40);
    apb(1, CTRL_A_IDX, {COM_CLEAR, COM_SET, 4'h3});
    apb(1, FLAGS_IDX, 8'h07);
    apb(1, CTRL_B_IDX, 8'h01);
    repeat (600) @(posedge core_clk);
    hi_count(256);
    `CHK("fast pwm high", 1'b1, (hi >= 64 && hi <= 66))
    `CHK("fast pwm b high", 1'b1, (hib >= 190 && hib <= 192))
    `CHK("ovf at max", 1'b1, overflowFlag)
    apb(1, CTRL_B_IDX, 8'h00);
  endtask

  // TOP taken from compare A: the count never reaches MAX yet the flag sets
  task t_fast_top;
    apb(1, COUNT_IDX, 8'h00);
    apb(1, FLAGS_IDX, 8'h07);
    // The clear lands on the access edge, so look one clock later
    @(posedge core_clk);
    `CHK("ovf cleared", 1'b0, overflowFlag)
    apb(1, CMP_A_IDX, 8'h20);
    apb(1, CTRL_A_IDX, 8'h03);
    apb(1, CTRL_B_IDX, 8'h09);
    repeat (100) @(posedge core_clk);
    `CHK("ovf at top", 1'b1, overflowFlag)
    apb(0, COUNT_IDX, 8'h00); `CHK("top wrap", 1'b1, (rdv <= 8'h20))
    apb(1, CTRL_B_IDX, 8'h00);
  endtask

  task t_ctc;
    logic prev;
    int n;
    apb(1, COUNT_IDX, 8'h00);
    apb(1, CMP_A_IDX, 8'h09);
    apb(1, CMP_B_IDX, 8'h04);
    apb(1, CTRL_A_IDX, {COM_TOGGLE, COM_TOGGLE, 4'h2});
    apb(1, FLAGS_IDX, 8'h07);
    apb(1, CTRL_B_IDX, 8'h01);
    for (int k = 0; k < 2; k++) begin
      prev = chanAWaveOut;
      n = 0;
      while (chanAWaveOut === prev && n < 40) begin
        @(posedge core_clk);
        n++;
      end
    end
    `CHK("ctc period", 10, n)
    repeat (300) @(posedge core_clk);
    `CHK("no ovf in ctc", 1'b0, overflowFlag)
    apb(1, CTRL_B_IDX, 8'h00);
  endtask

  task t_phase;
    apb(1, CMP_A_IDX, 8'h80);
    apb(1, CMP_B_IDX, 8'h40);
    apb(1, CTRL_A_IDX, {COM_CLEAR, COM_SET, 4'h1});
    apb(1, CTRL_B_IDX, 8'h01);
    repeat (1100) @(posedge core_clk);
    hi_count(510);
    `CHK("phase pwm high", 1'b1, (hi >= 254 && hi <= 258))
    `CHK("phase pwm b high", 1'b1, (hib >= 380 && hib <= 384))
    apb(1, CTRL_B_IDX, 8'h00);
  endtask

  task t_clock_sel;
    logic [7:0] held;
    apb(1, CTRL_A_IDX, 8'h00);
    for (int i = 0; i < 7; i++) begin
      apb(1, COUNT_IDX, 8'h00);
      apb(1, CTRL_B_IDX, 8'(i + 1));
      repeat (divs[i] * 20) @(posedge core_clk);
      apb(1, CTRL_B_IDX, 8'h00);
      apb(0, COUNT_IDX, 8'h00); `CHK("divided count", 1'b1, (rdv >= 19 && rdv <= 24))
    end
    held = rdv;
    repeat (50) @(posedge core_clk);
    apb(0, COUNT_IDX, 8'h00); `CHK("stopped count", held, rdv)
    // Reserved mode 4 freezes the counter even with a clock selected
    apb(1, COUNT_IDX, 8'h05);
    apb(1, CTRL_B_IDX, 8'h09);
    repeat (50) @(posedge core_clk);
    apb(0, COUNT_IDX, 8'h00); `CHK("reserved frozen", 8'h05, rdv)
    apb(1, CTRL_B_IDX, 8'h00);
  endtask

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    err_total = 0;
    total_checks = 0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_force();
    t_fast_pwm();
    t_fast_top();
    t_ctc();
    t_phase();
    t_clock_sel();
    results();
  end
endmodule
